// ### tsfl_top.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module tsfl_top
  import tsfl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  input wire logic carrier_sense_in,
  input wire logic collision_in,
  input wire logic rx_activity_in,
  input wire logic tx_preamble_start_in,
  input wire logic tx_sfd_in,
  input wire logic tx_last_byte_in,
  input wire logic monitor_done_in,
  input wire logic monitor_crc_bad_in,
  input wire logic monitor_align_err_in,
  input wire logic monitor_sa_miss_in,
  input wire logic status_written_in,
  output logic tx_abort_out,
  output logic tx_retry_out,
  output logic status_valid_out,
  output logic [15:0] packet_status_word_out
);

  typedef struct packed {
    logic crs_s1;
    logic crs_s2;
    logic col_s1;
    logic col_s2;
    logic col_prev;
    logic act_s1;
    logic act_s2;
    tsfl_state_e st;
    logic loopback;
    logic origin_sel;
    logic retrying;
    logic no_carrier_flag;
    logic carrier_lost_flag;
    logic excess_collision_flag;
    logic late_collision_flag;
    logic monitored_bad_flag;
    logic status_valid;
    logic abort;
    logic retry;
    logic [15:0] rdata;
  } tsfl_top_s;

  tsfl_top_s q;
  tsfl_top_s d;
  logic col_edge;
  logic in_span;
  logic new_pkt;
  logic [15:0] status_word;

  tsfl_coll_if ci ();

  tsfl_coll u_coll (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ci(ci)
  );

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  assign col_edge = q.col_s2 && !q.col_prev;
  assign in_span = (q.st == ST_PRE && tx_sfd_in) || q.st == ST_SPAN;
  assign new_pkt = q.st == ST_IDLE && tx_preamble_start_in && !q.retrying;

  assign ci.attempt_start = q.st == ST_IDLE && tx_preamble_start_in;
  assign ci.sfd = q.st == ST_PRE && tx_sfd_in;
  assign ci.origin_sel = q.origin_sel;
  assign ci.col = col_edge && (q.st == ST_PRE || q.st == ST_SPAN);
  assign ci.new_pkt = new_pkt;

  always_comb
  begin
    status_word = 16'h0000;
    status_word[TSFL_ST_NO_CARRIER_BIT] = q.no_carrier_flag;
    status_word[TSFL_ST_CARRIER_LOST_BIT] = q.carrier_lost_flag;
    status_word[TSFL_ST_EXCESS_BIT] = q.excess_collision_flag;
    status_word[TSFL_ST_LATE_BIT] = q.late_collision_flag;
    status_word[TSFL_ST_RSVD_BIT] = 1'b0;
    status_word[TSFL_ST_MON_BAD_BIT] = q.monitored_bad_flag;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.abort = 1'b0;
    d.retry = 1'b0;
    d.rdata = 16'h0000;
    // Only the second stage and col_prev are read by logic; the first is a pure synchroniser
    d.crs_s1 = carrier_sense_in;
    d.crs_s2 = q.crs_s1;
    d.col_s1 = collision_in;
    d.col_s2 = q.col_s1;
    d.col_prev = q.col_s2;
    d.act_s1 = rx_activity_in;
    d.act_s2 = q.act_s1;

    if (reg_wr_in && reg_addr_in == TSFL_OFS_CTRL)
    begin
      d.loopback = reg_wdata_in[TSFL_CTRL_LOOPBACK_BIT];
      d.origin_sel = reg_wdata_in[TSFL_CTRL_ORIGIN_BIT];
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        TSFL_OFS_CTRL:
        begin
          d.rdata[TSFL_CTRL_LOOPBACK_BIT] = q.loopback;
          d.rdata[TSFL_CTRL_ORIGIN_BIT] = q.origin_sel;
        end
        TSFL_OFS_STATUS:
        begin
          d.rdata = status_word;
        end
        default:
        begin
          d.rdata = 16'h0000;
        end
      endcase
    end

    case (q.st)
      ST_IDLE:
      begin
        if (tx_preamble_start_in)
        begin
          if (!q.retrying)
          begin
            d.carrier_lost_flag = 1'b0;
            d.excess_collision_flag = 1'b0;
            d.monitored_bad_flag = 1'b0;
          end
          d.no_carrier_flag = 1'b1;
          d.st = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (tx_sfd_in)
        begin
          d.st = ST_SPAN;
        end
      end
      ST_SPAN:
      begin
        if (tx_last_byte_in)
        begin
          d.st = ST_DONE;
          d.status_valid = 1'b1;
        end
      end
      ST_DONE:
      begin
        if (status_written_in)
        begin
          d.st = ST_IDLE;
          d.status_valid = 1'b0;
          d.retrying = 1'b0;
          d.late_collision_flag = 1'b0;
        end
      end
      default:
      begin
        d.st = ST_IDLE;
      end
    endcase

    // Carrier only records; the frame runs on regardless
    if (in_span)
    begin
      if (q.crs_s2 && (!q.loopback || q.act_s2))
      begin
        d.no_carrier_flag = 1'b0;
      end
      if (!q.crs_s2 || q.loopback)
      begin
        d.carrier_lost_flag = 1'b1;
      end
    end

    if (ci.col)
    begin
      if (ci.late)
      begin
        d.late_collision_flag = 1'b1;
      end
      if (ci.sixteenth)
      begin
        d.excess_collision_flag = 1'b1;
        d.abort = 1'b1;
        d.st = ST_DONE;
        d.status_valid = 1'b1;
      end
      else
      begin
        // Late and ordinary collisions share the same backoff path
        d.retry = 1'b1;
        d.retrying = 1'b1;
        d.st = ST_IDLE;
      end
    end

    // A late monitor verdict sets over any clear in the same cycle
    if (monitor_done_in && ((monitor_crc_bad_in && monitor_align_err_in)
      || monitor_sa_miss_in))
    begin
      d.monitored_bad_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      q <= '0;
      q.st <= ST_IDLE;
      q.loopback <= TSFL_RST_LOOPBACK;
      q.origin_sel <= TSFL_RST_ORIGIN;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign tx_abort_out = q.abort;
  assign tx_retry_out = q.retry;
  assign status_valid_out = q.status_valid;
  assign packet_status_word_out = {7'h00, q.no_carrier_flag, q.carrier_lost_flag, q.excess_collision_flag,
    q.late_collision_flag, 1'b0, q.monitored_bad_flag, 3'h0};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_nocarr_preamble: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.st == ST_IDLE && tx_preamble_start_in && !col_edge) |=> q.no_carrier_flag && q.st == ST_PRE)
    else $error("no-carrier not set at preamble");
  chk_crs_clears_nocarr: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_span && q.crs_s2 && !q.loopback) |=> !q.no_carrier_flag)
    else $error("carrier seen but no-carrier kept");
  chk_abort_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    q.abort |-> $past(col_edge) && q.excess_collision_flag && q.status_valid)
    else $error("abort without sixteenth collision");
  chk_loop_nocarr: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_span && q.loopback && !q.act_s2 && q.no_carrier_flag) |=> q.no_carrier_flag)
    else $error("loopback cleared no-carrier");
  chk_crs_lost: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_span && !q.crs_s2) |=> q.carrier_lost_flag)
    else $error("carrier-lost not set");
  chk_both_flags: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(q.status_valid) && !q.excess_collision_flag && q.no_carrier_flag) |-> q.carrier_lost_flag)
    else $error("no-carrier without carrier-lost");
  chk_loop_lost: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_span && q.loopback) |=> q.carrier_lost_flag)
    else $error("loopback packet lacks carrier-lost");
  chk_late_retry: assert property (@(posedge clk_in) disable iff (rst_in)
    (ci.col && ci.late && !ci.sixteenth) |=> q.retry && !q.abort && q.late_collision_flag ##1 !q.retry)
    else $error("late collision not retried");
  chk_late_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.st == ST_DONE && status_written_in) |=> !q.late_collision_flag && !q.status_valid)
    else $error("late flag kept after write-back");
  chk_mon_bad_set: assert property (@(posedge clk_in) disable iff (rst_in)
    (monitor_done_in && (monitor_sa_miss_in || (monitor_crc_bad_in && monitor_align_err_in))) |=> q.monitored_bad_flag)
    else $error("monitored-bad not set");
  chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    reg_rd_in && reg_addr_in == TSFL_OFS_STATUS |=> reg_rdata_out[TSFL_ST_RSVD_BIT] == 1'b0)
    else $error("reserved bit read nonzero");

  // ----------------------------------------
  // Flag lifetime, span transition and collision outcome checks
  // ----------------------------------------
  chk_new_pkt_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    new_pkt |=> !q.carrier_lost_flag && !q.excess_collision_flag && q.no_carrier_flag && q.st == ST_PRE)
    else $error("new packet flags not reset");
  chk_nocarr_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.no_carrier_flag && !(in_span && q.crs_s2)) |=> q.no_carrier_flag)
    else $error("no-carrier cleared without carrier");
  chk_sfd_enters_span: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.st == ST_PRE && tx_sfd_in && !ci.col) |=> q.st == ST_SPAN)
    else $error("delimiter did not open span");
  chk_last_closes_span: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.st == ST_SPAN && tx_last_byte_in && !ci.col) |=> q.status_valid && q.st == ST_DONE)
    else $error("last byte did not close span");
  chk_span_no_abort: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_span && !ci.col) |=> !q.abort)
    else $error("abort without collision");
  chk_loop_act_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    (in_span && q.loopback && q.crs_s2 && q.act_s2) |=> !q.no_carrier_flag)
    else $error("loopback with activity kept no-carrier");
  chk_lost_needs_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    (!q.carrier_lost_flag && !(in_span && (!q.crs_s2 || q.loopback))) |=> !q.carrier_lost_flag)
    else $error("carrier-lost set without cause");
  chk_abort_sixteenth: assert property (@(posedge clk_in) disable iff (rst_in)
    (ci.col && ci.sixteenth) |=> q.abort && q.excess_collision_flag && q.st == ST_DONE)
    else $error("sixteenth collision not aborted");
  chk_abort_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    q.abort |=> !q.abort)
    else $error("abort longer than one cycle");
  chk_excess_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.excess_collision_flag && !new_pkt) |=> q.excess_collision_flag)
    else $error("excess flag dropped early");
  chk_plain_retry: assert property (@(posedge clk_in) disable iff (rst_in)
    (ci.col && !ci.sixteenth) |=> q.retry && !q.abort && q.st == ST_IDLE)
    else $error("collision not retried");
  chk_retry_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    q.retry |=> !q.retry)
    else $error("retry longer than one cycle");
  chk_retry_abort_excl: assert property (@(posedge clk_in) disable iff (rst_in)
    !(q.retry && q.abort))
    else $error("retry and abort together");
  chk_late_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.late_collision_flag && !(q.st == ST_DONE && status_written_in)) |=> q.late_collision_flag)
    else $error("late flag dropped before write-back");
  chk_crc_only_clean: assert property (@(posedge clk_in) disable iff (rst_in)
    (!q.monitored_bad_flag && monitor_done_in && !monitor_sa_miss_in && !monitor_align_err_in) |=> !q.monitored_bad_flag)
    else $error("crc error without alignment set monitored-bad");
  chk_mon_bad_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.monitored_bad_flag && !new_pkt) |=> q.monitored_bad_flag)
    else $error("monitored-bad dropped early");
  chk_sa_miss_bad: assert property (@(posedge clk_in) disable iff (rst_in)
    (monitor_done_in && monitor_sa_miss_in) |=> q.monitored_bad_flag)
    else $error("address miss not flagged");

  cov_full_packet: cover property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_SPAN && tx_last_byte_in ##1 q.status_valid);
  cov_excess_abort: cover property (@(posedge clk_in) disable iff (rst_in) q.abort);
  cov_late_collision: cover property (@(posedge clk_in) disable iff (rst_in) ci.late);
  cov_loopback_pkt: cover property (@(posedge clk_in) disable iff (rst_in)
    in_span && q.loopback && !q.act_s2);
  cov_late_retry: cover property (@(posedge clk_in) disable iff (rst_in)
    ci.late ##1 q.retry);

endmodule

// ### tsfl_pkg.sv
// Function
// - No-carrier set at preamble, cleared on carrier
// - Carrier sampled from delimiter to last byte
// - Carrier loss never aborts a transmission
// - Loopback keeps no-carrier set without receive activity
// - Carrier-lost set when carrier low in span
// - No carrier ever gives both flags together
// - Loopback packets always set carrier-lost
// - Sixteenth collision aborts, sets excess flag
// - Collision beyond one slot sets late flag
// - Origin select picks preamble or delimiter reference
// - Late collision backs off and retries normally
// - Late flag cleared once status word written
// - Alignment-caused CRC error sets monitored-bad
// - Unmatched source address sets monitored-bad
package tsfl_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] TSFL_OFS_CTRL = 8'h00;
  localparam logic [7:0] TSFL_OFS_STATUS = 8'h04;
  localparam int TSFL_CTRL_LOOPBACK_BIT = 0;
  localparam int TSFL_CTRL_ORIGIN_BIT = 1;
  localparam logic TSFL_RST_LOOPBACK = 1'b0;
  localparam logic TSFL_RST_ORIGIN = 1'b0;

  // ----------------------------------------
  // Status word fields
  // ----------------------------------------
  localparam int TSFL_ST_NO_CARRIER_BIT = 8;
  localparam int TSFL_ST_CARRIER_LOST_BIT = 7;
  localparam int TSFL_ST_EXCESS_BIT = 6;
  localparam int TSFL_ST_LATE_BIT = 5;
  localparam int TSFL_ST_RSVD_BIT = 4;
  localparam int TSFL_ST_MON_BAD_BIT = 3;

  // ----------------------------------------
  // Timing and counts
  // ----------------------------------------
  localparam int TSFL_CLK_PERIOD_NS = 40;
  localparam int TSFL_SLOT_TIME_NS = 51200;
  // Rounded down: the slot is a longest time before a collision turns late
  localparam logic [10:0] TSFL_SLOT_CYC = 11'(TSFL_SLOT_TIME_NS / TSFL_CLK_PERIOD_NS);
  localparam logic [10:0] TSFL_TIMER_MAX = 11'h7FF;
  localparam logic [4:0] TSFL_COLL_LIMIT = 5'h10;

  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_SPAN, ST_DONE} tsfl_state_e;

endpackage

// ### tsfl_coll_if.sv
`timescale 1ns/1ns
interface tsfl_coll_if;
  logic attempt_start;
  logic sfd;
  logic origin_sel;
  logic col;
  logic new_pkt;
  logic sixteenth;
  logic late;
  modport ctl (output attempt_start, output sfd, output origin_sel, output col, output new_pkt,
    input sixteenth, input late);
  modport cnt (input attempt_start, input sfd, input origin_sel, input col, input new_pkt,
    output sixteenth, output late);
endinterface

// ### tsfl_coll.sv
`timescale 1ns/1ns
module tsfl_coll
  import tsfl_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  tsfl_coll_if.cnt ci
);

  typedef struct packed {
    logic [10:0] timer;
    logic running;
    logic [4:0] count;
  } tsfl_coll_s;

  tsfl_coll_s q;
  tsfl_coll_s d;
  logic ref_hit;

  // ----------------------------------------
  // Slot timer and collision count
  // ----------------------------------------
  always_comb
  begin
    d = q;
    ref_hit = ci.origin_sel ? ci.sfd : ci.attempt_start;
    if (ref_hit)
    begin
      d.timer = 11'h000;
      d.running = 1'b1;
    end
    else if (ci.attempt_start)
    begin
      d.running = 1'b0;
    end
    else if (q.running && q.timer != TSFL_TIMER_MAX)
    begin
      d.timer = q.timer + 11'h001;
    end
    if (ci.col)
    begin
      d.count = q.count + 5'h01;
      d.running = 1'b0;
    end
    if (ci.new_pkt)
    begin
      d.count = 5'h00;
    end
  end

  // A collision in the preamble before a delimiter origin is never late
  assign ci.late = ci.col && q.running && (q.timer > TSFL_SLOT_CYC);
  assign ci.sixteenth = ci.col && (q.count == TSFL_COLL_LIMIT - 5'h01);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  chk_late_needs_slot: assert property (@(posedge clk_in) disable iff (rst_in)
    ci.late |-> q.timer > TSFL_SLOT_CYC && q.running) else $error("late collision inside slot");
  chk_early_not_late: assert property (@(posedge clk_in) disable iff (rst_in)
    (ci.col && q.running && q.timer <= TSFL_SLOT_CYC) |-> !ci.late) else $error("early collision marked late");
  chk_origin_restart: assert property (@(posedge clk_in) disable iff (rst_in)
    (ci.origin_sel && ci.sfd && !ci.col) |=> q.timer == 11'h000 && q.running) else $error("origin not restarted");

endmodule

// ### tsfl_medium.sv
`timescale 1ns/1ns
module tsfl_medium
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tx_active_in,
  input wire logic crs_on_in,
  input wire logic [1:0] crs_lag_in,
  input wire logic coll_req_in,
  output logic carrier_sense_out,
  output logic collision_out
);
  // ----------------------------------------
  // Carrier echo and collision jam
  // ----------------------------------------
  // Idle medium shows no carrier; a slow medium echoes late
  logic [3:0] echo_q;
  logic [2:0] jam_q;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      echo_q <= 4'h0;
      jam_q <= 3'h0;
    end
    else
    begin
      echo_q <= {echo_q[2:0], tx_active_in & crs_on_in};
      if (coll_req_in)
        jam_q <= 3'h4;
      else if (jam_q != 3'h0)
        jam_q <= jam_q - 3'h1;
    end
  end
  assign carrier_sense_out = echo_q[crs_lag_in];
  assign collision_out = jam_q != 3'h0;
endmodule

// ### tsfl_top_tb_top.sv
`timescale 1ns/1ns
module tsfl_top_tb_top;
  import tsfl_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] ev = 5'h00;
  logic mcrc = 1'b0;
  logic malign = 1'b0;
  logic msa = 1'b0;
  logic rx_act = 1'b0;
  logic tx_act = 1'b0;
  logic crs_on = 1'b0;
  logic [1:0] lag = 2'h0;
  logic coll_req = 1'b0;
  logic crs;
  logic col;
  logic [15:0] rdata;
  logic [15:0] psw;
  logic abort;
  logic retry;
  logic valid;
  logic [2:0] outs;
  logic [2:0] seen;
  logic [15:0] d;
  int failures = 0;
  int checked = 0;
  int aborts = 0;
  int cycles = 0;
  assign outs = {valid, abort, retry};
  always #20 clk_in = ~clk_in;

  tsfl_medium u_medium (.clk_in(clk_in), .rst_in(rst_in), .tx_active_in(tx_act), .crs_on_in(crs_on),
    .crs_lag_in(lag), .coll_req_in(coll_req), .carrier_sense_out(crs), .collision_out(col));
  tsfl_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .carrier_sense_in(crs), .collision_in(col),
    .rx_activity_in(rx_act), .tx_preamble_start_in(ev[0]), .tx_sfd_in(ev[1]), .tx_last_byte_in(ev[2]),
    .monitor_done_in(ev[3]), .monitor_crc_bad_in(mcrc), .monitor_align_err_in(malign),
    .monitor_sa_miss_in(msa), .status_written_in(ev[4]), .tx_abort_out(abort), .tx_retry_out(retry),
    .status_valid_out(valid), .packet_status_word_out(psw));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= 5'h00;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [15:0] q);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    q = rdata;
  endtask

  // Bounded wait so a silent design cannot hang the run
  task automatic wait_out(input logic [2:0] m, output logic [2:0] s);
    int n;
    n = 0;
    s = 3'h0;
    while ((s & m) == 3'h0 && n < 40)
    begin
      @(negedge clk_in);
      s = outs;
      n++;
    end
  endtask

  task automatic collide(output logic [2:0] s);
    @(posedge clk_in);
    coll_req <= 1'b1;
    @(posedge clk_in);
    coll_req <= 1'b0;
    wait_out(3'h3, s);
  endtask

  task automatic frame(input logic c, input logic drop, input logic [2:0] mon, input logic [15:0] exp);
    logic [2:0] s;
    logic [15:0] q;
    @(posedge clk_in);
    tx_act <= 1'b1;
    crs_on <= c;
    pulse(5'h01);
    tick(8);
    pulse(5'h02);
    tick(6);
    crs_on <= c & ~drop;
    tick(6);
    pulse(5'h04);
    tx_act <= 1'b0;
    {msa, malign, mcrc} <= mon;
    pulse(5'h08);
    wait_out(3'h4, s);
    check({13'h0000, s}, 16'h0004);
    reg_read(TSFL_OFS_STATUS, q);
    check(q, exp);
    check(psw, exp);
    pulse(5'h10);
    @(negedge clk_in);
    check({15'h0000, valid}, 16'h0000);
  endtask

  task automatic late_try(input logic origin, input logic [15:0] exp);
    reg_write(TSFL_OFS_CTRL, {14'h0000, origin, 1'b0});
    @(posedge clk_in);
    tx_act <= 1'b1;
    crs_on <= 1'b1;
    pulse(5'h01);
    tick(100);
    pulse(5'h02);
    tick(1200);
    collide(seen);
    check({14'h0000, seen[1:0]}, 16'h0001);
    reg_read(TSFL_OFS_STATUS, d);
    check(d, exp);
    tick(8);
    frame(1'b1, 1'b0, 3'h0, exp);
    reg_read(TSFL_OFS_STATUS, d);
    check(d, 16'h0000);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  // Sampled mid-cycle so a one-cycle abort pulse is counted exactly once
  always @(negedge clk_in)
  begin
    cycles++;
    if (abort === 1'b1)
      aborts++;
    if (cycles == 12000)
    begin
      failures++;
      complete_run();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_read(TSFL_OFS_STATUS, d);
    check(d, 16'h0000);
    reg_write(TSFL_OFS_STATUS, 16'hFFFF);
    reg_read(TSFL_OFS_STATUS, d);
    check(d, 16'h0000);
    reg_write(8'h08, 16'hFFFF);
    reg_read(8'h08, d);
    check(d, 16'h0000);
    reg_write(TSFL_OFS_CTRL, 16'h0003);
    reg_read(TSFL_OFS_CTRL, d);
    check(d, 16'h0003);
    reg_write(TSFL_OFS_CTRL, 16'h0000);
    frame(1'b1, 1'b0, 3'h0, 16'h0000);
    @(posedge clk_in);
    lag <= 2'h3;
    frame(1'b1, 1'b0, 3'h1, 16'h0000);
    frame(1'b1, 1'b0, 3'h3, 16'h0008);
    frame(1'b1, 1'b0, 3'h4, 16'h0008);
    frame(1'b0, 1'b0, 3'h0, 16'h0180);
    frame(1'b1, 1'b1, 3'h0, 16'h0080);
    reg_write(TSFL_OFS_CTRL, 16'h0001);
    frame(1'b1, 1'b0, 3'h0, 16'h0180);
    @(posedge clk_in);
    rx_act <= 1'b1;
    frame(1'b1, 1'b0, 3'h0, 16'h0080);
    @(posedge clk_in);
    rx_act <= 1'b0;
    reg_write(TSFL_OFS_CTRL, 16'h0000);
    @(posedge clk_in);
    tx_act <= 1'b1;
    crs_on <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      pulse(5'h01);
      tick(8);
      pulse(5'h02);
      collide(seen);
      check({14'h0000, seen[1:0]}, (i == 15) ? 16'h0002 : 16'h0001);
      tick(8);
    end
    wait_out(3'h4, seen);
    check(psw, 16'h0040);
    @(posedge clk_in);
    tx_act <= 1'b0;
    pulse(5'h10);
    late_try(1'b0, 16'h0020);
    late_try(1'b1, 16'h0000);
    check(16'(aborts), 16'h0001);
    complete_run();
  end
endmodule
